// file: design/interlock_force_and_diagnostics.sv
// Force setting, indicators and error handling of the solenoid interlock
//
// Behaviour
// - Adjustment mode holds both safety outputs off.
// - After target removal yellow repeats bursts whose count is the level plus one.
// - Each one-second placement with guard open steps the level by one.
// - Level seven plus one placement wraps to level zero.
// - Power loss stores the level and ends adjustment mode.
// - Power-up with guard open shows stored level on yellow for ten seconds.
// - Final burst of that ten-second display may be cut short.
// - Serial variant takes level from request bits 1 to 3.
// - Levels map to 30..100 N, or 45..115 N with magnet.
// - Green shows supply, yellow switching state, red faults.
// - Internal error drops safety outputs at once.
// - Error warning drops safety outputs only after thirty minutes.
// - Cleared error indication needs the guard opened.
// - Error warning clears itself when its cause goes.
// - Multiple output faults lock the device until power cycle.
// - Diagnostic output drops on fault or warning before outputs go.
// - Closed guard unlocked: yellow flashes; locked: yellow steady, all high.
// - Lock commanded but failed: yellow flashes, diag per variant.
// - Forced separation: red and yellow flash, all outputs low.
// - Safety outputs need actuator, lock and force above 500 N.
// - Forced separation switches outputs off within 150 ms.
//
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "interlock_defs.svh"
module interlock_force_and_diagnostics
   import interlock_pkg::*;
#(
   parameter longint ADJ_ENTRY_CYC = `MS_CYC(`ADJ_ENTRY_S * 1000),
   parameter longint SHOW_CYC = `MS_CYC(`SHOW_S * 1000),
   parameter longint PLACE_CYC = `MS_CYC(`PLACE_MS),
   parameter longint WARN_CYC = `MS_CYC(`WARN_MIN * 60 * 1000),
   parameter longint FLASH_CYC = `MS_CYC(`FLASH_MS),
   parameter longint GAP_CYC = `MS_CYC(`GAP_MS)
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [3:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire sense_type sense,
   input wire logic target_present,
   input wire logic internal_error,
   input wire logic warn_cause,
   input wire logic [1:0] output_fault,
   input wire logic separation,
   input wire logic [`LVL_W-1:0] stored_level,
   output logic [`LVL_W-1:0] store_level,
   output logic store_strobe,
   output logic first_safety_output,
   output logic second_safety_output,
   output logic diag_out,
   output led_type leds
);
   ////////////////////////////////////////////////////////////////////////////
   // Helpers
   function automatic logic [`LVL_W-1:0] next_level(input logic [`LVL_W-1:0] l);
      next_level = (l == `LVL_MAX) ? `LVL_RESET : l + 3'h1;
   endfunction : next_level

   function automatic logic [7:0] force_n(input logic [`LVL_W-1:0] l, input logic mag);
      force_n = 8'((mag ? `MAG_FORCE_N : `BASE_FORCE_N) + `STEP_N * int'(l));
   endfunction : force_n

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   logic [2:0] ctrl_q;
   logic [`LVL_W-1:0] req_lvl_q;
   logic req_valid_q;
   logic ack_q;
   mode_type mode_q;
   logic [`LVL_W-1:0] level_q;
   logic [31:0] tmr_q;
   logic [31:0] place_q;
   logic placed_q;
   logic [`BLINK_W-1:0] blink_q;
   logic [3:0] burst_q;
   logic flash_q;
   logic error_q;
   logic lockout_q;
   logic warn_q;
   logic [39:0] warn_tmr_q;
   logic warn_expired_q;
   logic sep_q;
   logic slow_q;
   logic [`BLINK_W-1:0] slow_cnt_q;

   wire serial_diag_variant = ctrl_q[0];
   wire lock_aware_diag_variant = ctrl_q[1];
   wire magnet_boosted_variant = ctrl_q[2];
   wire req = (avs_read | avs_write) & ~ack_q;

   ////////////////////////////////////////////////////////////////////////////
   // Avalon slave, one wait state
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ack_q <= 1'b0;
         avs_waitrequest <= 1'b1;
         avs_readdata <= 32'h0;
         ctrl_q <= 3'h0;
         req_lvl_q <= `LVL_RESET;
         req_valid_q <= 1'b0;
      end
      else
      begin
         ack_q <= req;
         avs_waitrequest <= ~req;
         req_valid_q <= 1'b0;
         if (req && avs_write)
         begin
            case (avs_address)
               `REG_CTRL: ctrl_q <= avs_writedata[2:0];
               `REG_REQ:
               begin
                  req_lvl_q <= avs_writedata[`REQ_LVL_MSB:`REQ_LVL_LSB];
                  req_valid_q <= 1'b1;
               end
               default: ;
            endcase
         end
         if (req && avs_read)
         begin
            case (avs_address)
               `REG_CTRL: avs_readdata <= {29'h0, ctrl_q};
               `REG_STAT: avs_readdata <= {24'h0, lockout_q, sep_q, warn_expired_q,
                                           warn_q, error_q, mode_q};
               `REG_LVL: avs_readdata <= {13'h0, force_n(level_q, magnet_boosted_variant),
                                          8'h0, level_q};
               `REG_REQ: avs_readdata <= {28'h0, req_lvl_q, 1'b0};
               default: avs_readdata <= 32'h0;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Mode and level
   wire place_done = target_present && (place_q == 32'(PLACE_CYC - 1)) && !placed_q;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mode_q <= ST_BOOT;
         level_q <= `LVL_RESET;
         tmr_q <= 32'h0;
      end
      else
      begin
         case (mode_q)
            ST_BOOT:
            begin
               level_q <= stored_level;
               tmr_q <= 32'h0;
               if (target_present)
                  mode_q <= ST_ENTRY;
               else if (!sense.guard_closed)
                  mode_q <= ST_SHOW;
               else
                  mode_q <= ST_RUN;
            end
            ST_ENTRY:
            begin
               tmr_q <= tmr_q + 32'h1;
               if (!target_present)
                  mode_q <= ST_RUN;
               else if (tmr_q == 32'(ADJ_ENTRY_CYC - 1))
                  mode_q <= ST_ADJ;
            end
            ST_ADJ:
            begin
               if (place_done && !sense.guard_closed)
                  level_q <= next_level(level_q);
            end
            ST_SHOW:
            begin
               tmr_q <= tmr_q + 32'h1;
               if (tmr_q == 32'(SHOW_CYC - 1))
                  mode_q <= ST_RUN;
            end
            ST_RUN:
            begin
               if (serial_diag_variant && req_valid_q)
                  level_q <= req_lvl_q;
            end
            default: mode_q <= ST_BOOT;
         endcase
      end
   end

   // Level offered to non-volatile store; stored when supply drops
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         store_level <= `LVL_RESET;
         store_strobe <= 1'b0;
      end
      else
      begin
         store_level <= level_q;
         store_strobe <= (mode_q == ST_ADJ) || (mode_q == ST_RUN && serial_diag_variant);
      end
   end

   // Placement debounce
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         place_q <= 32'h0;
         placed_q <= 1'b0;
      end
      else if (!target_present)
      begin
         place_q <= 32'h0;
         placed_q <= 1'b0;
      end
      else
      begin
         if (place_q != 32'(PLACE_CYC - 1))
            place_q <= place_q + 32'h1;
         if (place_done)
            placed_q <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flash burst generator
   wire burst_done = !flash_q && (burst_q == {1'b0, level_q} + 4'h1);
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         blink_q <= '0;
         burst_q <= 4'h0;
         flash_q <= 1'b0;
      end
      else if (!((mode_q == ST_ADJ && !target_present) || mode_q == ST_SHOW))
      begin
         blink_q <= '0;
         burst_q <= 4'h0;
         flash_q <= 1'b0;
      end
      else if (blink_q == `BLINK_W'(burst_done ? GAP_CYC - 1 : FLASH_CYC - 1))
      begin
         blink_q <= '0;
         if (flash_q)
            flash_q <= 1'b0;
         else if (burst_done)
            burst_q <= 4'h0;
         else
         begin
            flash_q <= 1'b1;
            burst_q <= burst_q + 4'h1;
         end
      end
      else
         blink_q <= blink_q + `BLINK_W'(1);
   end
   // Slow flash for status display
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         slow_cnt_q <= '0;
         slow_q <= 1'b0;
      end
      else if (slow_cnt_q == `BLINK_W'(FLASH_CYC - 1))
      begin
         slow_cnt_q <= '0;
         slow_q <= ~slow_q;
      end
      else
         slow_cnt_q <= slow_cnt_q + `BLINK_W'(1);
   end

   ////////////////////////////////////////////////////////////////////////////
   // Errors and warnings
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         error_q <= 1'b0;
         lockout_q <= 1'b0;
         sep_q <= 1'b0;
      end
      else
      begin
         if (internal_error)
            error_q <= 1'b1;
         else if (!sense.guard_closed)
            error_q <= 1'b0;
         if (&output_fault)
            lockout_q <= 1'b1;
         if (separation)
            sep_q <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         warn_q <= 1'b0;
         warn_tmr_q <= 40'h0;
         warn_expired_q <= 1'b0;
      end
      else
      begin
         warn_q <= warn_cause | (|output_fault);
         if (!(warn_cause | (|output_fault)))
         begin
            warn_tmr_q <= 40'h0;
            warn_expired_q <= 1'b0;
         end
         else if (warn_tmr_q == 40'(WARN_CYC - 1))
            warn_expired_q <= 1'b1;
         else
            warn_tmr_q <= warn_tmr_q + 40'h1;
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   wire halt = error_q | lockout_q | sep_q | separation | internal_error | warn_expired_q;
   wire enable = (mode_q == ST_RUN) && !halt && sense.guard_closed && sense.actuator_in
                 && sense.locked && sense.force_ok;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         first_safety_output <= 1'b0;
         second_safety_output <= 1'b0;
         diag_out <= 1'b0;
         leds <= '0;
      end
      else
      begin
         first_safety_output <= enable;
         second_safety_output <= enable;
         if (halt || warn_q || !sense.guard_closed)
            diag_out <= 1'b0;
         else if (sense.lock_cmd && !sense.locked)
            diag_out <= !lock_aware_diag_variant;
         else
            diag_out <= 1'b1;
         leds.green <= 1'b1;
         leds.red <= (error_q | lockout_q | warn_q | sep_q) & slow_q;
         if (mode_q == ST_ADJ || mode_q == ST_SHOW)
            leds.yellow <= flash_q;
         else if (sep_q)
            leds.yellow <= slow_q;
         else if (!sense.guard_closed || error_q)
            leds.yellow <= 1'b0;
         else if (sense.locked)
            leds.yellow <= 1'b1;
         else
            leds.yellow <= slow_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   adj_outputs_off_a: assert property (@(posedge clk) disable iff (!rstn)
      mode_q == ST_ADJ |=> !first_safety_output && !second_safety_output)
      else $error("safety output on in adjustment");
   err_outputs_off_a: assert property (@(posedge clk) disable iff (!rstn)
      internal_error |=> !first_safety_output)
      else $error("output stayed on after internal error");
   wrap_level_a: assert property (@(posedge clk) disable iff (!rstn)
      mode_q == ST_ADJ && place_done && !sense.guard_closed && level_q == `LVL_MAX
      |=> level_q == `LVL_RESET)
      else $error("level did not wrap");
   lockout_sticky_a: assert property (@(posedge clk) disable iff (!rstn)
      lockout_q |=> lockout_q && !first_safety_output)
      else $error("lockout released");
   diag_warn_a: assert property (@(posedge clk) disable iff (!rstn)
      warn_q |=> !diag_out)
      else $error("diag high during warning");
   sep_off_a: assert property (@(posedge clk) disable iff (!rstn)
      separation |=> ##1 !first_safety_output && !second_safety_output && !diag_out)
      else $error("separation outputs not low");
   serial_level_a: assert property (@(posedge clk) disable iff (!rstn)
      mode_q == ST_RUN && serial_diag_variant && req_valid_q |=> level_q == $past(req_lvl_q))
      else $error("serial level not taken");
   single_step_a: assert property (@(posedge clk) disable iff (!rstn)
      mode_q == ST_ADJ && placed_q && $stable(mode_q) |=> $stable(level_q))
      else $error("level stepped twice");
endmodule : interlock_force_and_diagnostics

// file: design/interlock_defs.svh
// Constants of the interlock force and diagnostics block
`ifndef INTERLOCK_DEFS_SVH
`define INTERLOCK_DEFS_SVH
`define CLK_MHZ 200
`define ADJ_ENTRY_S 10
`define SHOW_S 10
`define PLACE_MS 1000
`define WARN_MIN 30
`define SEP_MS 150
`define FLASH_MS 200
`define GAP_MS 1000
`define MS_CYC(ms) (longint'(ms) * 1000 * `CLK_MHZ)
`define LVL_W 3
`define LVL_RESET 3'h0
`define LVL_MAX 3'h7
`define REQ_LVL_LSB 1
`define REQ_LVL_MSB 3
`define BASE_FORCE_N 30
`define MAG_FORCE_N 45
`define STEP_N 10
`define REG_CTRL 4'h0
`define REG_STAT 4'h4
`define REG_LVL 4'h8
`define REG_REQ 4'hc
`define BLINK_W 28
`endif

// file: design/interlock_pkg.sv
// Types of the interlock force and diagnostics block
package interlock_pkg;
   typedef enum logic [2:0]
   {
      ST_BOOT = 3'h0,
      ST_ENTRY = 3'h1,
      ST_ADJ = 3'h2,
      ST_SHOW = 3'h3,
      ST_RUN = 3'h4
   } mode_type;
   typedef struct packed
   {
      logic green;
      logic yellow;
      logic red;
   } led_type;
   typedef struct packed
   {
      logic guard_closed;
      logic actuator_in;
      logic lock_cmd;
      logic locked;
      logic force_ok;
   } sense_type;
endpackage : interlock_pkg

// file: dv/target_operator.sv
// Operator that places the adjustment target for a set time
`timescale 1ns/1ps
module target_operator
(
   input wire logic clk,
   input wire logic place,
   input wire logic [15:0] hold_cyc,
   output logic target_present
);
   logic [15:0] left_q = 16'h0;
   always @(posedge clk)
   begin
      if (place && left_q == 16'h0)
         left_q <= hold_cyc;
      else if (left_q != 16'h0)
         left_q <= left_q - 16'h1;
   end
   assign target_present = (left_q != 16'h0);
endmodule : target_operator

// file: dv/interlock_force_and_diagnostics_bench.sv
// Self-checking bench of the interlock force and diagnostics block
`timescale 1ns/1ps
`include "interlock_defs.svh"
module interlock_force_and_diagnostics_bench;
   import interlock_pkg::*;
   localparam int ADJ = 20;
   localparam int PLC = 20;
   localparam int WRN = 60;
   localparam int FLS = 4;
   localparam int GAP = 10;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] avs_address = 4'h0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   sense_type sense = '0;
   logic target_present;
   logic place = 1'b0;
   logic [15:0] hold_cyc = 16'h0;
   logic internal_error = 1'b0;
   logic warn_cause = 1'b0;
   logic [1:0] output_fault = 2'h0;
   logic separation = 1'b0;
   logic [2:0] stored_level = 3'h0;
   logic [2:0] store_level;
   logic store_strobe;
   logic first_safety_output;
   logic second_safety_output;
   logic diag_out;
   led_type leds;
   logic [31:0] want_q[$];
   logic [31:0] mask_q[$];
   int errors = 0;
   int num_checks = 0;
   int seed = 92489;
   int red_n;
   int yel_n;
   logic [2:0] lvl;
   always #2.5 clk = ~clk;
   ////////////////////////////////////////////////////////////////////////////////
   interlock_force_and_diagnostics #(.ADJ_ENTRY_CYC(ADJ), .SHOW_CYC(100), .PLACE_CYC(PLC),
      .WARN_CYC(WRN), .FLASH_CYC(FLS), .GAP_CYC(GAP)) dut (.clk(clk), .rstn(rstn),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .sense(sense), .target_present(target_present),
      .internal_error(internal_error), .warn_cause(warn_cause), .output_fault(output_fault),
      .separation(separation), .stored_level(stored_level), .store_level(store_level),
      .store_strobe(store_strobe), .first_safety_output(first_safety_output),
      .second_safety_output(second_safety_output), .diag_out(diag_out), .leds(leds));
   target_operator op (.clk(clk), .place(place), .hold_cyc(hold_cyc),
      .target_present(target_present));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      num_checks++;
      if (seen !== want)
      begin
         errors++;
         $display("BAD %0t seen %h want %h", $time, seen, want);
      end
   endtask : check
   task automatic close_out;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : close_out
   task automatic bus(input logic wr, input logic [3:0] addr, input logic [31:0] data);
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= addr;
      avs_writedata <= data;
      avs_read <= ~wr;
      avs_write <= wr;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0 && n < 50);
      if (n >= 50)
      begin
         errors++;
         close_out();
      end
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask : bus
   task automatic rd(input logic [3:0] addr, input logic [31:0] want, input logic [31:0] mask);
      want_q.push_back(want);
      mask_q.push_back(mask);
      bus(1'b0, addr, 32'h0);
   endtask : rd
   task automatic power(input sense_type s, input logic tgt);
      @(posedge clk);
      rstn <= 1'b0;
      sense <= s;
      place <= tgt;
      hold_cyc <= 16'(ADJ + 40);
      repeat (3) @(posedge clk);
      place <= 1'b0;
      rstn <= 1'b1;
      repeat (4) @(posedge clk);
   endtask : power
   function automatic logic [31:0] lvl_word(input logic [2:0] l);
      return (32'(`BASE_FORCE_N + `STEP_N * l) << 11) | 32'(l);
   endfunction : lvl_word
   task automatic count_flashes(input logic [2:0] l);
      int rises;
      logic prev;
      rises = 0;
      prev = leds.yellow;
      repeat (2 * FLS * (int'(l) + 1) + GAP)
      begin
         @(posedge clk);
         rises += int'(leds.yellow === 1'b1 && prev === 1'b0);
         prev = leds.yellow;
      end
      check(32'(rises), 32'(l) + 32'h1);
   endtask : count_flashes
   task automatic outs(input logic [2:0] want);
      check({29'h0, first_safety_output, second_safety_output, diag_out}, {29'h0, want});
   endtask : outs
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk)
   begin
      if (avs_read && avs_waitrequest === 1'b0 && want_q.size() > 0)
         check(avs_readdata & mask_q.pop_front(), want_q.pop_front());
   end
   initial
   begin
      stored_level <= 3'($random(seed));
      power(5'h0, 1'b1);
      lvl = stored_level;
      rd(`REG_LVL, lvl_word(lvl), 32'h7ff87);
      repeat (ADJ + 45) @(posedge clk);
      rd(`REG_STAT, 32'(ST_ADJ), 32'h7);
      rd(4'h2, 32'h0, 32'hffffffff);
      for (int i = 0; i < 9; i++)
      begin
         place <= 1'b1;
         hold_cyc <= 16'(PLC + 5);
         @(posedge clk);
         place <= 1'b0;
         repeat (PLC + 12) @(posedge clk);
         lvl = lvl + 3'h1;
         rd(`REG_LVL, lvl_word(lvl), 32'h7ff87);
         check(32'({store_strobe, store_level}), 32'({1'b1, lvl}));
         count_flashes(lvl);
      end
      sense <= 5'h1f;
      repeat (5) @(posedge clk);
      outs(3'b001);
      $display("adjust done");
      stored_level <= store_level;
      power(5'h1f, 1'b0);
      rd(`REG_STAT, 32'(ST_RUN), 32'hff);
      rd(`REG_LVL, lvl_word(lvl), 32'h7ff87);
      outs(3'b111);
      check(32'(leds), 32'h6);
      sense <= 5'h1c;
      repeat (3) @(posedge clk);
      outs(3'b001);
      bus(1'b1, `REG_CTRL, 32'h2);
      repeat (3) @(posedge clk);
      outs(3'b000);
      bus(1'b1, `REG_CTRL, 32'h1);
      for (int i = 0; i < 4; i++)
      begin
         lvl = 3'($random(seed));
         bus(1'b1, `REG_REQ, 32'({lvl, 1'b0}));
         repeat (3) @(posedge clk);
         rd(`REG_LVL, lvl_word(lvl), 32'h7ff87);
      end
      bus(1'b1, `REG_CTRL, 32'h5);
      rd(`REG_LVL, (32'(`MAG_FORCE_N + `STEP_N * lvl) << 11) | 32'(lvl), 32'h7ff87);
      sense <= 5'h1f;
      internal_error <= 1'b1;
      repeat (3) @(posedge clk);
      outs(3'b000);
      internal_error <= 1'b0;
      repeat (3) @(posedge clk);
      rd(`REG_STAT, 32'h8, 32'h8);
      sense <= 5'h0;
      repeat (3) @(posedge clk);
      sense <= 5'h1f;
      repeat (3) @(posedge clk);
      rd(`REG_STAT, 32'h0, 32'h8);
      outs(3'b111);
      $display("error done");
      warn_cause <= 1'b1;
      repeat (WRN / 2) @(posedge clk);
      outs(3'b110);
      warn_cause <= 1'b0;
      repeat (3) @(posedge clk);
      rd(`REG_STAT, 32'h0, 32'h10);
      outs(3'b111);
      warn_cause <= 1'b1;
      repeat (WRN + 10) @(posedge clk);
      outs(3'b000);
      rd(`REG_STAT, 32'h30, 32'h30);
      warn_cause <= 1'b0;
      power(5'h1f, 1'b0);
      output_fault <= 2'h3;
      repeat (3) @(posedge clk);
      output_fault <= 2'h0;
      sense <= 5'h0;
      repeat (3) @(posedge clk);
      sense <= 5'h1f;
      repeat (3) @(posedge clk);
      rd(`REG_STAT, 32'h80, 32'h80);
      outs(3'b000);
      power(5'h1f, 1'b0);
      rd(`REG_STAT, 32'h0, 32'h80);
      separation <= 1'b1;
      @(posedge clk);
      separation <= 1'b0;
      @(posedge clk);
      @(posedge clk);
      outs(3'b000);
      red_n = 0;
      yel_n = 0;
      repeat (60)
      begin
         @(posedge clk);
         red_n += int'(leds.red === 1'b1);
         yel_n += int'(leds.yellow === 1'b1);
      end
      check(32'(red_n > 0 && red_n < 60 && yel_n > 0 && yel_n < 60), 32'h1);
      $display("run done");
      power(5'h0, 1'b0);
      rd(`REG_STAT, 32'(ST_SHOW), 32'h7);
      count_flashes(stored_level);
      repeat (110) @(posedge clk);
      rd(`REG_STAT, 32'(ST_RUN), 32'h7);
      $display("show done");
      close_out();
   end
endmodule : interlock_force_and_diagnostics_bench
